/* logic/adc_regs_pkg.sv */
// Shared constants and carrier types for the converter status and identification registers
package adc_regs_pkg;

	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;

	// Register addresses
	localparam logic [5:0] ADDR_IDENT = 6'h00;
	localparam logic [5:0] ADDR_STATUS = 6'h01;
	localparam logic [5:0] ADDR_MODE = 6'h02;

	// Reset values
	localparam logic [15:0] STATUS_RESET = 16'h0500;
	localparam logic [15:0] MODE_RESET = 16'h0510;

	// Identification word fields
	localparam int ID_CHAN_LSB = 8;
	localparam logic [3:0] ID_CHANNEL_COUNT = 4'h2;
	// Arbitrary values, carry no meaning
	localparam logic [3:0] ID_UPPER_NIBBLE = 4'h7;
	localparam logic [7:0] ID_LOW_BYTE = 8'h3c;

	// Status word bit positions
	localparam int ST_LOCK = 15;
	localparam int ST_RESYNC = 14;
	localparam int ST_REGMAP = 13;
	localparam int ST_CRC_ERR = 12;
	localparam int ST_CRC_TYPE = 11;
	localparam int ST_RESET = 10;
	localparam int ST_WLEN_LSB = 8;
	localparam int ST_CH1 = 1;
	localparam int ST_CH0 = 0;

	// Mode word bit positions
	localparam int MD_REG_CRC_EN = 13;
	localparam int MD_RX_CRC_EN = 12;
	localparam int MD_CRC_TYPE = 11;
	localparam int MD_RESET = 10;
	localparam int MD_WLEN_LSB = 8;
	localparam int MD_TIMEOUT = 4;

	// Sticky event flags, index into the flag vector
	localparam int NUM_FLAGS = 5;
	localparam int FL_RESYNC = 0;
	localparam int FL_REGMAP = 1;
	localparam int FL_CRC_ERR = 2;
	localparam int FL_CH0 = 3;
	localparam int FL_CH1 = 4;

	typedef enum logic [1:0] {
		WIDTH_16,
		WIDTH_24,
		WIDTH_32_ZERO,
		WIDTH_32_SIGN
	} word_width_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [5:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic locked;
		logic resync_evt;
		logic regmap_crc_chg_evt;
		logic rx_crc_err_evt;
		logic [1:0] new_sample_evt;
		logic [1:0] sample_taken;
	} adc_events_t;

endpackage

/* logic/sticky_flag.sv */
// Sticky flag cell: an event sets it, a clear drops it, the set wins
`timescale 1ns/1ps
`default_nettype none
module sticky_flag #(
	parameter logic RESET_VALUE = 1'b0
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic set_in,
	input wire logic clear_in,
	// Flag
	output logic flag_out
);

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			flag_out <= RESET_VALUE;
		end else if (set_in) begin
			// An event in the clearing cycle must not be lost
			flag_out <= 1'b1;
		end else if (clear_in) begin
			flag_out <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* logic/adc_status_id_registers.sv */
// Identification, status and mode registers of the two-channel converter
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Address 0 identification word, channel count bits 11:8
// - Identification low byte arbitrary, host ignores it
// - Status at address 1, resets to 0500h
// - Bit 15 shows interface lock, 0 after reset
// - Bit 14 set on every resynchronization
// - Bit 13 set when register-map checksum changes
// - Bit 12 set on input frame checksum error
// - Bit 11 shows checksum type, 0 CCITT
// - Bit 10 set by reset until acknowledged
// - Bits 9:8 show sample word width
// - Bit 1 flags new channel 1 sample
// - Bit 0 flags new channel 0 sample
// - Mode word at address 2, resets 0510h
// - Writing 0 to mode reset bit clears flag
// - Status checksum type mirrors mode selection bit
// - Status word width mirrors mode width field
// - Input checksum errors count only when enabled
module adc_status_id_registers
	import adc_regs_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Register access from the serial frame engine
	input wire adc_regs_pkg::reg_req_t req_in,
	output logic [15:0] rdata_out,
	output logic ack_out,
	// Events from the converter core
	input wire adc_regs_pkg::adc_events_t events_in,
	// Configuration towards the core
	output logic [15:0] mode_out,
	output logic crc_type_ansi_out,
	output logic rx_crc_en_out,
	output logic reg_crc_en_out,
	output adc_regs_pkg::word_width_t word_width_out,
	// Status word as seen by the frame engine
	output logic [15:0] status_out
);

	import adc_regs_pkg::*;

	// Mode word held field by field
	logic [1:0] mode_top_reg;
	logic reg_crc_en_reg;
	logic rx_crc_en_reg;
	logic crc_type_reg;
	logic mode_rst_bit_reg;
	logic [1:0] width_sel_reg;
	logic [7:0] mode_low_reg;
	logic [15:0] mode_reg;
	logic reset_seen_reg;
	logic lock_reg;
	logic [NUM_FLAGS-1:0] flag_set;
	logic [NUM_FLAGS-1:0] flag_clear;
	logic [NUM_FLAGS-1:0] flags;
	logic status_read;
	logic mode_write;
	logic [15:0] status_next;
	logic [15:0] rdata_next;

	function automatic logic [15:0] ident_word();
		ident_word = {ID_UPPER_NIBBLE, ID_CHANNEL_COUNT, ID_LOW_BYTE};
	endfunction

	function automatic logic hit(input reg_req_t r, input logic [5:0] a, input logic wr);
		hit = r.valid && (r.write == wr) && (r.addr == a);
	endfunction

	// Bit 10 always shows the flag, never the stored write value
	function automatic logic [15:0] mode_view(input logic [15:0] m, input logic rs);
		mode_view = {m[15:MD_RESET+1], rs, m[MD_RESET-1:0]};
	endfunction

	// Only a status read acknowledges the resync, map checksum and input checksum flags
	assign status_read = hit(req_in, ADDR_STATUS, 1'b0);
	assign mode_write = hit(req_in, ADDR_MODE, 1'b1);

	// Event sources and their clears
	always_comb begin
		flag_set = '0;
		flag_set[FL_RESYNC] = events_in.resync_evt;
		flag_set[FL_REGMAP] = events_in.regmap_crc_chg_evt;
		flag_set[FL_CRC_ERR] = events_in.rx_crc_err_evt && mode_reg[MD_RX_CRC_EN];
		flag_set[FL_CH0] = events_in.new_sample_evt[0];
		flag_set[FL_CH1] = events_in.new_sample_evt[1];
	end

	// Checksum flags drop when a status read has seen them, sample flags when the core takes the sample
	always_comb begin
		flag_clear = '0;
		flag_clear[FL_RESYNC] = status_read;
		flag_clear[FL_REGMAP] = status_read;
		flag_clear[FL_CRC_ERR] = status_read;
		flag_clear[FL_CH0] = events_in.sample_taken[0];
		flag_clear[FL_CH1] = events_in.sample_taken[1];
	end

	// One sticky cell per event flag
	genvar gi;
	generate
		for (gi = 0; gi < NUM_FLAGS; gi = gi + 1) begin : g_flag
			sticky_flag #(
				.RESET_VALUE(1'b0)
			) u_flag (
				.clk_in(clk_in),
				.rst_n_in(rst_n_in),
				.set_in(flag_set[gi]),
				.clear_in(flag_clear[gi]),
				.flag_out(flags[gi])
			);
		end
	endgenerate

	// Reserved top bits stored as written
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			mode_top_reg <= MODE_RESET[15:MD_REG_CRC_EN+1];
		end else if (mode_write) begin
			mode_top_reg <= req_in.wdata[15:MD_REG_CRC_EN+1];
		end
	end

	// Register map checksum enable
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			reg_crc_en_reg <= MODE_RESET[MD_REG_CRC_EN];
		end else if (mode_write) begin
			reg_crc_en_reg <= req_in.wdata[MD_REG_CRC_EN];
		end
	end

	// Input frame checking enable, off after reset
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rx_crc_en_reg <= MODE_RESET[MD_RX_CRC_EN];
		end else if (mode_write) begin
			rx_crc_en_reg <= req_in.wdata[MD_RX_CRC_EN];
		end
	end

	// Checksum type selection
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			crc_type_reg <= MODE_RESET[MD_CRC_TYPE];
		end else if (mode_write) begin
			crc_type_reg <= req_in.wdata[MD_CRC_TYPE];
		end
	end

	// Reset bit as written; the flag itself lives apart
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			mode_rst_bit_reg <= MODE_RESET[MD_RESET];
		end else if (mode_write) begin
			mode_rst_bit_reg <= req_in.wdata[MD_RESET];
		end
	end

	// Word width selection, 24 bits after reset
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			width_sel_reg <= MODE_RESET[MD_WLEN_LSB +: 2];
		end else if (mode_write) begin
			width_sel_reg <= req_in.wdata[MD_WLEN_LSB +: 2];
		end
	end

	// Low byte stored as written
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			mode_low_reg <= MODE_RESET[MD_WLEN_LSB-1:0];
		end else if (mode_write) begin
			mode_low_reg <= req_in.wdata[MD_WLEN_LSB-1:0];
		end
	end

	assign mode_reg = {mode_top_reg, reg_crc_en_reg, rx_crc_en_reg, crc_type_reg, mode_rst_bit_reg,
		width_sel_reg, mode_low_reg};

	// Reset-occurred flag: only a written 0 acknowledges it
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			reset_seen_reg <= STATUS_RESET[ST_RESET];
		end else if (mode_write && !req_in.wdata[MD_RESET]) begin
			reset_seen_reg <= 1'b0;
		end
	end

	// Lock level comes from same-clock logic, registered once
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			lock_reg <= STATUS_RESET[ST_LOCK];
		end else begin
			lock_reg <= events_in.locked;
		end
	end

	// Status assembly, reserved bits forced low
	always_comb begin
		status_next = '0;
		status_next[ST_LOCK] = lock_reg;
		status_next[ST_RESYNC] = flags[FL_RESYNC];
		status_next[ST_REGMAP] = flags[FL_REGMAP];
		status_next[ST_CRC_ERR] = flags[FL_CRC_ERR];
		status_next[ST_CRC_TYPE] = mode_reg[MD_CRC_TYPE];
		status_next[ST_RESET] = reset_seen_reg;
		status_next[ST_WLEN_LSB +: 2] = mode_reg[MD_WLEN_LSB +: 2];
		status_next[ST_CH1] = flags[FL_CH1];
		status_next[ST_CH0] = flags[FL_CH0];
	end

	// Read decode; writes to read-only words fall through untouched
	always_comb begin
		rdata_next = '0;
		if (req_in.valid && !req_in.write) begin
			unique case (req_in.addr)
				ADDR_IDENT: rdata_next = ident_word();
				ADDR_STATUS: rdata_next = status_next;
				ADDR_MODE: rdata_next = mode_view(mode_reg, reset_seen_reg);
				default: rdata_next = '0;
			endcase
		end
	end

	// Read data, one cycle after the request
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= rdata_next;
		end
	end

	// Every address acknowledged, so a host never stalls on a bad one
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ack_out <= 1'b0;
		end else begin
			ack_out <= req_in.valid;
		end
	end

	// Mode word as read back
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			mode_out <= MODE_RESET;
		end else begin
			mode_out <= mode_view(mode_reg, reset_seen_reg);
		end
	end

	// Checksum type towards the core
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			crc_type_ansi_out <= MODE_RESET[MD_CRC_TYPE];
		end else begin
			crc_type_ansi_out <= mode_reg[MD_CRC_TYPE];
		end
	end

	// Input frame checking enable towards the core
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rx_crc_en_out <= MODE_RESET[MD_RX_CRC_EN];
		end else begin
			rx_crc_en_out <= mode_reg[MD_RX_CRC_EN];
		end
	end

	// Register map checksum enable towards the core
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			reg_crc_en_out <= MODE_RESET[MD_REG_CRC_EN];
		end else begin
			reg_crc_en_out <= mode_reg[MD_REG_CRC_EN];
		end
	end

	// Sample word width towards the core
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			word_width_out <= word_width_t'(MODE_RESET[MD_WLEN_LSB +: 2]);
		end else begin
			word_width_out <= word_width_t'(mode_reg[MD_WLEN_LSB +: 2]);
		end
	end

	// Status word, one cycle behind the flags; a read sees the fresher copy
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			status_out <= STATUS_RESET;
		end else begin
			status_out <= status_next;
		end
	end

endmodule
`default_nettype wire

/* verification/adc_status_sva.sv */
// Port checks for the status and identification register bank
`timescale 1ns/1ps
`default_nettype none
module adc_status_sva
	import adc_regs_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Watched ports
	input wire adc_regs_pkg::reg_req_t req_in,
	input wire logic [15:0] rdata_out,
	input wire logic ack_out,
	input wire adc_regs_pkg::adc_events_t events_in,
	input wire logic [15:0] mode_out,
	input wire logic rx_crc_en_out,
	input wire adc_regs_pkg::word_width_t word_width_out,
	input wire logic [15:0] status_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_req(w, a);
		req_in.valid && req_in.write == w && req_in.addr == a;
	endsequence
	sequence s_any_wr;
		req_in.valid && req_in.write;
	endsequence
	property p_ack;
		1'b1 |=> ack_out == $past(req_in.valid);
	endproperty
	property p_ident;
		s_req(1'b0, ADDR_IDENT) |=> rdata_out[11:8] == 4'h2;
	endproperty
	property p_wr_zero;
		s_any_wr |=> rdata_out == 16'h0000;
	endproperty
	// Reset itself is the cause here, so no disable
	property p_rst_val;
		disable iff (1'b0) !rst_n_in |=> status_out == 16'h0500 && mode_out == 16'h0510;
	endproperty
	property p_lock;
		$rose(events_in.locked) |-> ##[1:2] status_out[15];
	endproperty
	property p_resync;
		events_in.resync_evt |-> ##[1:2] status_out[14];
	endproperty
	property p_regmap;
		events_in.regmap_crc_chg_evt |-> ##[1:2] status_out[13];
	endproperty
	property p_crc_err;
		events_in.rx_crc_err_evt ##1 rx_crc_en_out |-> ##[0:1] status_out[12];
	endproperty
	property p_mirror;
		status_out[11:8] == mode_out[11:8] && word_width_out == mode_out[9:8];
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after request");
	a_ident: assert property (p_ident) else $error("channel count wrong");
	a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
	a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
	a_lock: assert property (p_lock) else $error("lock not shown");
	a_resync: assert property (p_resync) else $error("resync flag not set");
	a_regmap: assert property (p_regmap) else $error("map checksum flag not set");
	a_crc_err: assert property (p_crc_err) else $error("input checksum flag not set");
	a_mirror: assert property (p_mirror) else $error("status does not mirror mode");
	a_rsvd: assert property (status_out[7:2] == 6'h00) else $error("reserved bits set");
endmodule
bind adc_status_id_registers adc_status_sva u_sva (.clk_in, .rst_n_in, .req_in, .rdata_out, .ack_out,
	.events_in, .mode_out, .rx_crc_en_out, .word_width_out, .status_out);
`default_nettype wire

/* verification/host_model.sv */
// Host side register bus master
`timescale 1ns/1ps
`default_nettype none
module host_model
	import adc_regs_pkg::*;
(
	input wire logic clk_in,
	input wire logic ack_in,
	input wire logic [15:0] rdata_in,
	output adc_regs_pkg::reg_req_t req_out
);
	initial req_out = '0;
	task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		@(posedge clk_in);
		req_out <= '{1'b1, wr, a, d};
		@(posedge clk_in);
		// One-cycle strobe; stale fields inverted so nothing leans on them
		req_out <= '{1'b0, ~wr, ~a, ~d};
		do begin
			@(posedge clk_in);
			n++;
		end while (ack_in !== 1'b1 && n < 4);
		q = (ack_in === 1'b1) ? rdata_in : 16'hxxxx;
	endtask
endmodule
`default_nettype wire

/* verification/test_adc_status_id_registers.sv */
// Self-checking bench for the status and identification registers
`timescale 1ns/1ps
`default_nettype none
module test_adc_status_id_registers;
	import adc_regs_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	adc_events_t events_in = '0;
	reg_req_t req;
	logic [15:0] rdata_out, mode_out, status_out, q;
	logic ack_out, crc_type_ansi_out, rx_crc_en_out, reg_crc_en_out;
	word_width_t word_width_out;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	always #4 clk_in = ~clk_in;
	adc_status_id_registers DUT (.clk_in, .rst_n_in, .req_in(req), .rdata_out, .ack_out, .events_in,
		.mode_out, .crc_type_ansi_out, .rx_crc_en_out, .reg_crc_en_out, .word_width_out, .status_out);
	host_model host (.clk_in, .ack_in(ack_out), .rdata_in(rdata_out), .req_out(req));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		host.access(1'b0, a, 16'h0000, q);
		check(q, exp);
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		host.access(1'b1, a, d, q);
		check(q, 16'h0000);
	endtask
	// Lock is a level, so it survives the end of a pulse
	task automatic pulse(input logic [7:0] e);
		@(posedge clk_in);
		events_in <= e;
		@(posedge clk_in);
		events_in <= e & 8'h80;
	endtask
	task automatic do_reset();
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
	endtask
	task automatic t_reset();
		check(status_out, 16'h0500);
		host.access(1'b0, ADDR_IDENT, 16'h0000, q);
		check({12'h000, q[11:8]}, 16'h0002);
		rd(ADDR_STATUS, 16'h0500);
		rd(ADDR_MODE, 16'h0510);
		rd(6'h3f, 16'h0000);
	endtask
	task automatic t_events();
		pulse(8'hfc);
		rd(ADDR_STATUS, 16'he503);
		rd(ADDR_STATUS, 16'h8503);
		pulse(8'h81);
		rd(ADDR_STATUS, 16'h8502);
		wr(ADDR_STATUS, 16'hffff);
		wr(ADDR_IDENT, 16'h0000);
		rd(ADDR_STATUS, 16'h8502);
	endtask
	task automatic t_mode();
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_MODE, 16'h1c00 | 16'(i << 8));
			rd(ADDR_STATUS, 16'h8c02 | 16'(i << 8));
			check({14'h0, word_width_out}, 16'(i));
			check(mode_out, 16'h1c00 | 16'(i << 8));
			check({13'h0000, reg_crc_en_out, rx_crc_en_out, crc_type_ansi_out}, 16'h0003);
		end
		wr(ADDR_MODE, 16'h1900);
		pulse(8'h90);
		rd(ADDR_STATUS, 16'h9902);
		wr(ADDR_MODE, 16'h1d00);
		rd(ADDR_MODE, 16'h1900);
		pulse(8'h00);
		do_reset();
		rd(ADDR_STATUS, 16'h0500);
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		do_reset();
		t_reset();
		t_events();
		t_mode();
		complete_run();
	end
endmodule
`default_nettype wire
